// ---- rtl/serial_eeprom_pkg.sv ----
package serial_eeprom_pkg;

   // ===========================================================
   // Timing
   localparam int CORE_CLK_HZ         = 100_000_000;
   localparam int WRITE_CYCLE_TIME_MS = 5;
   localparam int WRITE_CYCLE_CYCLES  =
      WRITE_CYCLE_TIME_MS * (CORE_CLK_HZ / 1000);
   localparam int TIMER_W             = 19;

   // ===========================================================
   // Array geometry
   localparam int ARRAY_DEPTH = 128;
   localparam int ADDR_W      = 7;
   localparam int PAGE_SIZE   = 16;
   localparam int PAGE_W      = 4;

   // ===========================================================
   // Control byte layout
   localparam logic [3:0] DEVICE_CODE = 4'hA;
   localparam int         CODE_LSB    = 4;
   localparam int         CS_LSB      = 1;
   localparam int         DIR_BIT     = 0;

   // ===========================================================
   // Reset values
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [5:0] SYNC_RESET  = 6'h03;

   // ===========================================================
   // Synchroniser lanes
   localparam int SYNC_W  = 6;
   localparam int SCL_IDX = 0;
   localparam int SDA_IDX = 1;
   localparam int WP_IDX  = 2;
   localparam int CS_IDX  = 3;

   // ===========================================================
   // States
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RECEIVE,
      ST_ACK,
      ST_SEND,
      ST_MASTER_ACK,
      ST_IGNORE
   } bus_state_t;

   typedef enum logic [1:0] {
      KIND_CTRL,
      KIND_ADDR,
      KIND_DATA
   } byte_kind_t;

endpackage

// ---- rtl/bus_line_sync.sv ----
`timescale 1ns/10ps
module bus_line_sync import serial_eeprom_pkg::*; (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       sclPin,
   input  wire logic       sdaPin,
   input  wire logic       wpPin,
   input  wire logic       chipSelectPin0,
   input  wire logic       chipSelectPin1,
   input  wire logic       chipSelectPin2,
   output logic            sclLevel,
   output logic            sdaLevel,
   output logic            wpLevel,
   output logic [2:0]      csLevel,
   output logic            sclRise,
   output logic            sclFall,
   output logic            startSeen,
   output logic            stopSeen
);

   typedef struct packed {
      logic [SYNC_W-1:0] stage1;
      logic [SYNC_W-1:0] stage2;
      logic              sclPrev;
      logic              sdaPrev;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // ===========================================================
   // Two-stage synchroniser and edge history
   always_comb begin
      next_st         = st;
      next_st.stage1  = {chipSelectPin2, chipSelectPin1, chipSelectPin0,
                         wpPin, sdaPin, sclPin};
      next_st.stage2  = st.stage1;
      next_st.sclPrev = st.stage2[SCL_IDX];
      next_st.sdaPrev = st.stage2[SDA_IDX];
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= {SYNC_RESET, SYNC_RESET, 1'b1, 1'b1};
      end else begin
         st <= next_st;
      end
   end

   assign sclLevel  = st.stage2[SCL_IDX];
   assign sdaLevel  = st.stage2[SDA_IDX];
   assign wpLevel   = st.stage2[WP_IDX];
   assign csLevel   = st.stage2[CS_IDX+2:CS_IDX];
   assign sclRise   = sclLevel & ~st.sclPrev;
   assign sclFall   = ~sclLevel & st.sclPrev;
   // Data edges while the clock stays high
   assign startSeen = sclLevel & st.sclPrev & st.sdaPrev & ~sdaLevel;
   assign stopSeen  = sclLevel & st.sclPrev & ~st.sdaPrev & sdaLevel;

   // ===========================================================
   // Checks
   AST_START_EDGE: assert property (@(posedge core_clk) disable iff (!rst_n)
      startSeen |-> $past(sdaLevel) && !sdaLevel && $past(sclLevel)
                    && sclLevel)
      else $error("start flagged without falling data under high clock");

   AST_STOP_EDGE: assert property (@(posedge core_clk) disable iff (!rst_n)
      stopSeen |-> !$past(sdaLevel) && sdaLevel && $past(sclLevel)
                   && sclLevel)
      else $error("stop flagged without rising data under high clock");

endmodule

// ---- rtl/write_cycle_timer.sv ----
`timescale 1ns/10ps
module write_cycle_timer import serial_eeprom_pkg::*; #(
   parameter int CYCLES = WRITE_CYCLE_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic launch,
   output logic      busy
);

   typedef struct packed {
      logic               busy;
      logic [TIMER_W-1:0] remain;
   } timer_state_t;

   timer_state_t st;
   timer_state_t next_st;

   // ===========================================================
   // Self-timed write cycle
   always_comb begin
      next_st = st;
      if (launch && !st.busy) begin
         next_st.busy   = 1'b1;
         next_st.remain = TIMER_W'(CYCLES - 1);
      end else if (st.busy) begin
         if (st.remain == '0) begin
            next_st.busy = 1'b0;
         end else begin
            next_st.remain = st.remain - 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign busy = st.busy;

   // ===========================================================
   // Checks
   AST_TWC_START: assert property (@(posedge core_clk) disable iff (!rst_n)
      launch && !st.busy |=> st.busy
                             && st.remain == TIMER_W'(CYCLES - 1))
      else $error("write cycle did not start with full count");

   AST_TWC_END: assert property (@(posedge core_clk) disable iff (!rst_n)
      st.busy && st.remain == '0 |=> !st.busy)
      else $error("write cycle overran its count");

endmodule

// ---- rtl/serial_eeprom_slave.sv ----
`timescale 1ns/10ps
// Summary of operation
// - SDA fall with SCL high starts command
// - SDA rise with SCL high stops operation
// - One bit per SCL pulse, sampled high
// - Receiver pulls SDA low on ninth pulse
// - No acknowledge during internal write cycle
// - Unacknowledged read byte: release SDA high
// - Control byte: code, chip selects, direction
// - Acknowledge only code and pin match
// - Direction one reads, zero writes
// - Byte write: control, address, data, stop
// - Stop after data launches timed write
// - Protected write still acknowledged and timed
// - Page buffer committed only after stop
// - Low four pointer bits wrap in page
// - Protect pin high blocks all writes
// - Current read sends byte at pointer
// - Repeated start aborts write, keeps pointer
// - Master acknowledge requests next byte
// - Pointer increments, wraps 07Fh to 000h
// - Write cycle lasts at most 5 ms
module serial_eeprom_slave import serial_eeprom_pkg::*; #(
   parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOe,
   input  wire logic writeProtectPin,
   input  wire logic chipSelectPin0,
   input  wire logic chipSelectPin1,
   input  wire logic chipSelectPin2,
   output logic      writeBusy
);

   typedef struct packed {
      bus_state_t                           state;
      byte_kind_t                           kind;
      logic [2:0]                           bitCnt;
      logic                                 byteDone;
      logic                                 ackIt;
      logic                                 masterAck;
      logic                                 drive;
      logic [7:0]                           shift;
      logic [ADDR_W-1:0]                    ptr;
      logic                                 wrPending;
      logic [PAGE_SIZE-1:0]                 pageValid;
      logic [PAGE_SIZE-1:0][7:0]            pageBuf;
      logic [ARRAY_DEPTH-1:0][7:0]          mem;
   } core_state_t;

   core_state_t       st;
   core_state_t       next_st;
   logic              sclLevel;
   logic              sdaLevel;
   logic              wpLevel;
   logic [2:0]        csLevel;
   logic              sclRise;
   logic              sclFall;
   logic              startSeen;
   logic              stopSeen;
   logic              launchWrite;
   logic [7:0]        rxByte;
   logic [7:0]        readByte;

   // ===========================================================
   // Pointer step inside the current page
   function automatic logic [ADDR_W-1:0] pageStep(
      input logic [ADDR_W-1:0] ptr
   );
      pageStep = {ptr[ADDR_W-1:PAGE_W], ptr[PAGE_W-1:0] + 4'h1};
   endfunction

   // ===========================================================
   // Pin synchroniser and bus conditions
   bus_line_sync lineSync (
      .core_clk       (core_clk),
      .rst_n          (rst_n),
      .sclPin         (sclIn),
      .sdaPin         (sdaIn),
      .wpPin          (writeProtectPin),
      .chipSelectPin0 (chipSelectPin0),
      .chipSelectPin1 (chipSelectPin1),
      .chipSelectPin2 (chipSelectPin2),
      .sclLevel       (sclLevel),
      .sdaLevel       (sdaLevel),
      .wpLevel        (wpLevel),
      .csLevel        (csLevel),
      .sclRise        (sclRise),
      .sclFall        (sclFall),
      .startSeen      (startSeen),
      .stopSeen       (stopSeen)
   );

   // ===========================================================
   // Write cycle timer
   write_cycle_timer #(
      .CYCLES (WRITE_CYCLES)
   ) cycleTimer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .launch   (launchWrite),
      .busy     (writeBusy)
   );

   assign rxByte   = {st.shift[6:0], sdaLevel};
   assign readByte = st.mem[st.ptr];

   // ===========================================================
   // Protocol engine
   always_comb begin
      next_st     = st;
      launchWrite = 1'b0;
      if (startSeen) begin
         // Repeated start drops buffered data, keeps pointer
         next_st.state     = ST_RECEIVE;
         next_st.kind      = KIND_CTRL;
         next_st.bitCnt    = 3'h0;
         next_st.byteDone  = 1'b0;
         next_st.drive     = 1'b0;
         next_st.wrPending = 1'b0;
         next_st.pageValid = '0;
      end else if (stopSeen) begin
         next_st.state    = ST_IDLE;
         next_st.drive    = 1'b0;
         next_st.byteDone = 1'b0;
         if (st.wrPending) begin
            launchWrite       = 1'b1;
            next_st.wrPending = 1'b0;
            next_st.pageValid = '0;
            if (!wpLevel) begin
               for (int i = 0; i < PAGE_SIZE; i++) begin
                  if (st.pageValid[i]) begin
                     next_st.mem[{st.ptr[ADDR_W-1:PAGE_W],
                                  PAGE_W'(i)}] = st.pageBuf[i];
                  end
               end
            end
         end
      end else begin
         unique case (st.state)
            ST_IDLE, ST_IGNORE: begin
               next_st.drive = 1'b0;
            end
            ST_RECEIVE: begin
               if (sclRise) begin
                  next_st.shift  = rxByte;
                  next_st.bitCnt = st.bitCnt + 3'h1;
                  if (st.bitCnt == 3'h7) begin
                     next_st.byteDone = 1'b1;
                     next_st.ackIt    = !writeBusy;
                     unique case (st.kind)
                        KIND_CTRL: begin
                           next_st.ackIt = !writeBusy
                              && rxByte[7:CODE_LSB] == DEVICE_CODE
                              && rxByte[CODE_LSB-1:CS_LSB] == csLevel;
                        end
                        KIND_ADDR: begin
                           next_st.ptr = rxByte[ADDR_W-1:0];
                        end
                        KIND_DATA: begin
                           next_st.pageBuf[st.ptr[PAGE_W-1:0]] = rxByte;
                           next_st.pageValid[st.ptr[PAGE_W-1:0]] = 1'b1;
                           next_st.ptr       = pageStep(st.ptr);
                           next_st.wrPending = 1'b1;
                        end
                        default: begin
                           next_st.ackIt = 1'b0;
                        end
                     endcase
                  end
               end else if (sclFall && st.byteDone) begin
                  next_st.state    = ST_ACK;
                  next_st.drive    = st.ackIt;
                  next_st.byteDone = 1'b0;
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  next_st.bitCnt = 3'h0;
                  if (!st.ackIt) begin
                     next_st.state = ST_IGNORE;
                     next_st.drive = 1'b0;
                  end else if (st.kind == KIND_CTRL
                               && st.shift[DIR_BIT]) begin
                     next_st.state = ST_SEND;
                     next_st.shift = readByte;
                     next_st.drive = !readByte[7];
                     next_st.ptr   = st.ptr + 7'h01;
                  end else begin
                     next_st.state = ST_RECEIVE;
                     next_st.kind  = (st.kind == KIND_CTRL) ? KIND_ADDR
                                                            : KIND_DATA;
                     next_st.drive = 1'b0;
                  end
               end
            end
            ST_SEND: begin
               if (sclRise) begin
                  next_st.bitCnt = st.bitCnt + 3'h1;
                  if (st.bitCnt == 3'h7) begin
                     next_st.byteDone = 1'b1;
                  end
               end else if (sclFall) begin
                  if (st.byteDone) begin
                     next_st.state    = ST_MASTER_ACK;
                     next_st.drive    = 1'b0;
                     next_st.byteDone = 1'b0;
                  end else begin
                     next_st.shift = {st.shift[6:0], 1'b0};
                     next_st.drive = !st.shift[6];
                  end
               end
            end
            ST_MASTER_ACK: begin
               if (sclRise) begin
                  next_st.masterAck = !sdaLevel;
               end else if (sclFall) begin
                  next_st.bitCnt = 3'h0;
                  if (st.masterAck) begin
                     next_st.state = ST_SEND;
                     next_st.shift = readByte;
                     next_st.drive = !readByte[7];
                     next_st.ptr   = st.ptr + 7'h01;
                  end else begin
                     next_st.state = ST_IGNORE;
                     next_st.drive = 1'b0;
                  end
               end
            end
            default: begin
               next_st.state = ST_IDLE;
               next_st.drive = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st     <= '0;
         st.mem <= {ARRAY_DEPTH{ERASED_BYTE}};
      end else begin
         st <= next_st;
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe  = st.drive;

   // ===========================================================
   // Checks
   AST_START_TO_CTRL: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      startSeen |=> st.state == ST_RECEIVE && st.kind == KIND_CTRL
                    && st.bitCnt == 3'h0 && !sdaOe)
      else $error("start did not open control byte reception");

   AST_STOP_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
      stopSeen && !startSeen |=> st.state == ST_IDLE && !sdaOe)
      else $error("stop did not return engine to idle");

   AST_DRIVE_HIGH_STABLE: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      sclLevel && $past(sclLevel) && !$past(startSeen)
      && !$past(stopSeen) |-> $stable(sdaOe))
      else $error("data drive changed while clock high");

   AST_BUSY_NO_ACK: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      writeBusy |-> !sdaOe)
      else $error("line driven during write cycle");

   AST_CTRL_MATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
      st.state == ST_ACK && st.kind == KIND_CTRL && st.drive
      |-> st.shift[7:CODE_LSB] == DEVICE_CODE
          && st.shift[CODE_LSB-1:CS_LSB] == csLevel)
      else $error("control byte acknowledged without match");

   AST_DIRECTION: assert property (@(posedge core_clk) disable iff (!rst_n)
      st.state == ST_ACK && st.kind == KIND_CTRL && st.ackIt && sclFall
      && !startSeen && !stopSeen
      |=> st.state == ($past(st.shift[DIR_BIT]) ? ST_SEND
                                                : ST_RECEIVE))
      else $error("direction bit selected wrong operation");

   AST_READ_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
      st.state == ST_ACK && st.kind == KIND_CTRL && st.ackIt && sclFall
      && st.shift[DIR_BIT] && !startSeen && !stopSeen
      |=> st.shift == $past(readByte)
          && st.ptr == $past(st.ptr) + 7'h01)
      else $error("current read loaded wrong byte or pointer");

   AST_PAGE_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
      st.state == ST_RECEIVE && st.kind == KIND_DATA && sclRise
      && st.bitCnt == 3'h7 && !startSeen && !stopSeen
      |=> st.ptr[PAGE_W-1:0] == $past(st.ptr[PAGE_W-1:0]) + 4'h1
          && st.ptr[ADDR_W-1:PAGE_W]
             == $past(st.ptr[ADDR_W-1:PAGE_W]))
      else $error("page pointer left its page");

   AST_NO_EARLY_COMMIT: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      !launchWrite |=> st.mem == $past(st.mem))
      else $error("array changed without stop");

   AST_WP_KEEPS_ARRAY: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      launchWrite && wpLevel |=> st.mem == $past(st.mem))
      else $error("protected array was written");

   AST_WP_STILL_TIMED: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      launchWrite && wpLevel && !writeBusy |=> writeBusy)
      else $error("protected write skipped write cycle");

   AST_SEQ_NEXT: assert property (@(posedge core_clk) disable iff (!rst_n)
      st.state == ST_MASTER_ACK && sclFall && st.masterAck
      && !startSeen && !stopSeen
      |=> st.state == ST_SEND
          && st.ptr == $past(st.ptr) + 7'h01)
      else $error("master acknowledge did not advance read");

   AST_START_KEEPS_PTR: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      startSeen |=> st.ptr == $past(st.ptr) && !st.wrPending)
      else $error("repeated start disturbed pointer");

endmodule

// ---- bench/two_wire_master.sv ----
`timescale 1ns/10ps
// ===========================================================
// Bus master model, makes the serial clock
module two_wire_master (
   output logic      scl,
   output logic      sdaLow,
   input  wire logic sda
);
   logic [7:0] seenVal;
   event       seen;

   initial begin
      scl    = 1'h1;
      sdaLow = 1'h0;
   end

   // Start from idle bus or repeated start
   task automatic start_cond();
      if (scl === 1'h0) begin
         #20 sdaLow = 1'h0;
         #20 scl = 1'h1;
         #40;
      end
      sdaLow = 1'h1;
      #40 scl = 1'h0;
   endtask

   task automatic stop_cond();
      #20 sdaLow = 1'h1;
      #20 scl = 1'h1;
      #40 sdaLow = 1'h0;
      #80;
   endtask

   // Data changes only while clock is low
   task automatic bit_out(input logic b);
      #20 sdaLow = !b;
      #20 scl = 1'h1;
      #40 scl = 1'h0;
   endtask

   task automatic bit_in(output logic b);
      #20 sdaLow = 1'h0;
      #20 scl = 1'h1;
      #35 b = sda;
      #5 scl = 1'h0;
   endtask

   // Byte out, ninth clock for acknowledge
   task automatic send_byte(input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i]);
      end
      seenVal = 8'h00;
      bit_in(seenVal[0]);
      ->seen;
   endtask

   // Byte in, then master ack or final nack
   task automatic recv_byte(input logic last);
      for (int i = 7; i >= 0; i--) begin
         bit_in(seenVal[i]);
      end
      ->seen;
      bit_out(last);
   endtask
endmodule

// ---- bench/serial_eeprom_slave_test.sv ----
`timescale 1ns/10ps
module serial_eeprom_slave_test;
   import serial_eeprom_pkg::*;
   localparam int WCYC = 200;
   logic       core_clk = 1'h0;
   logic       rst_n    = 1'h0;
   logic       scl;
   logic       sdaLow;
   wire logic  sdaWire;
   logic       sdaOut;
   logic       sdaOe;
   logic       wp       = 1'h0;
   logic [2:0] cs       = 3'h0;
   logic       writeBusy;
   logic [7:0] mem [ARRAY_DEPTH];
   logic [7:0] expQ [$];
   string      nameQ [$];
   logic [6:0] ptr;
   int         fail_count = 0;
   int         tests_run  = 0;

   always #5 core_clk = ~core_clk;
   // Open-drain wire with pull-up
   assign sdaWire = ~sdaLow & ~(sdaOe & ~sdaOut);

   two_wire_master m (.scl(scl), .sdaLow(sdaLow), .sda(sdaWire));

   serial_eeprom_slave #(.WRITE_CYCLES(WCYC)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtectPin(wp),
      .chipSelectPin0(cs[0]), .chipSelectPin1(cs[1]),
      .chipSelectPin2(cs[2]), .writeBusy(writeBusy));

   // ===========================================================
   // Checking
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask

   task automatic give_verdict();
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic note(string what, logic [7:0] v);
      nameQ.push_back(what);
      expQ.push_back(v);
   endtask

   always @(m.seen) begin
      if (expQ.size() == 0) begin
         check("unexpected result", m.seenVal, 8'hXX);
      end else begin
         check(nameQ.pop_front(), m.seenVal, expQ.pop_front());
      end
   end

   // ===========================================================
   // Bus sequences
   task automatic align();
      @(posedge core_clk);
      #1;
   endtask

   task automatic wbyte(logic [7:0] d, logic nack);
      note("acknowledge", {7'h00, nack});
      m.send_byte(d);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < WCYC && writeBusy !== 1'h0; i++) begin
         align();
      end
      check("write cycle end", {7'h00, writeBusy}, 8'h00);
   endtask

   task automatic write_seq(logic [7:0] addr, int n);
      logic [7:0] d;
      logic [3:0] lo;
      align();
      m.start_cond();
      wbyte({DEVICE_CODE, cs, 1'h0}, 1'h0);
      wbyte(addr, 1'h0);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         lo = addr[3:0] + 4'(i);
         if (!wp) mem[{addr[6:4], lo}] = d;
         wbyte(d, 1'h0);
      end
      m.stop_cond();
      check("write busy", {7'h00, writeBusy}, 8'h01);
      m.start_cond();
      wbyte({DEVICE_CODE, cs, 1'h0}, 1'h1);
      m.stop_cond();
      wait_idle();
      align();
      m.start_cond();
      wbyte({DEVICE_CODE, cs, 1'h0}, 1'h0);
      m.stop_cond();
   endtask

   task automatic read_bytes(int n);
      for (int i = 0; i < n; i++) begin
         note("read data", mem[ptr]);
         ptr = ptr + 7'h01;
         m.recv_byte(i == n - 1);
      end
      m.stop_cond();
   endtask

   task automatic read_seq(logic [7:0] addr, int n);
      align();
      m.start_cond();
      wbyte({DEVICE_CODE, cs, 1'h0}, 1'h0);
      wbyte(addr, 1'h0);
      m.start_cond();
      wbyte({DEVICE_CODE, cs, 1'h1}, 1'h0);
      ptr = addr[6:0];
      read_bytes(n);
   endtask

   // ===========================================================
   // Main sequence
   initial begin
      void'($urandom(79643));
      foreach (mem[i]) mem[i] = ERASED_BYTE;
      repeat (20) @(posedge core_clk);
      #1 rst_n = 1'h1;
      cs = 3'($urandom);
      repeat (5) align();
      m.start_cond();
      wbyte({4'h5, cs, 1'h0}, 1'h1);
      m.stop_cond();
      align();
      m.start_cond();
      wbyte({DEVICE_CODE, ~cs, 1'h0}, 1'h1);
      m.stop_cond();
      write_seq(8'h85, 1);
      read_seq(8'h05, 1);
      write_seq(8'h7C, 18);
      read_seq(8'h74, 14);
      align();
      m.start_cond();
      wbyte({DEVICE_CODE, cs, 1'h1}, 1'h0);
      read_bytes(1);
      wp = 1'h1;
      write_seq(8'h10, 2);
      align();
      wp = 1'h0;
      read_seq(8'h10, 2);
      check("pending results", 8'(expQ.size()), 8'h00);
      give_verdict();
   end

   initial begin
      #400us;
      fail_count++;
      give_verdict();
   end
endmodule
